// [src/ism_core.sv]
// Two-wire bus controller core: own-address and general call matching,
// a transmit-only master with arbitration, and one combined interrupt.
// Assumes open-drain pins resolved outside and a same-clock register port.
//
// Design decisions made here: the address map and the strobed register port.
`include "ism_map.svh"
module ism_core
  import ism_pkg::*;
#(
  parameter int HALF_CYC = `ISM_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            irq
);
  localparam int CW = $clog2(2 * HALF_CYC + 2);

  // Below four cycles the mid-low data change would collide with the clock edge.
  if (HALF_CYC < 4) begin : gHalfCheck
    $error("HALF_CYC below 4 cycles cannot be served");
  end

  ism_ctrl_type ctrl_q;
  ism_evt_type  evt_q, evtEn_q, evtSet;
  ism_sst_type  sState_q;
  ism_sst_type  sNext_q;
  ism_mst_type  mState_q;
  logic [7:0] own_q, extId_q, data_q, shift_q, txShift_q, rdata_q;
  logic [3:0] bitCnt_q, mBit_q;
  logic [CW-1:0] mCnt_q;
  logic sclS1_q, sclS2_q, sclD_q, sdaS1_q, sdaS2_q, sdaD_q;
  logic busy_q, skipFall_q, rxak_q, dir_q, tenHeard_q, sAck_q;
  logic doneFlag_q, matchFlag_q, arbFlag_q, irqFlag_q, irq_q;
  logic mShift7, mSda_q, mScl_q, mHave_q, mstPrev_q, sclOe_q, sdaOe_q;
  logic [7:0] mShift_q;

  // Two flip-flops on each pin before anything looks at it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sclD_q  <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      sdaD_q  <= 1'b1;
    end else begin
      sclS1_q <= sclIn;
      sclS2_q <= sclS1_q;
      sclD_q  <= sclS2_q;
      sdaS1_q <= sdaIn;
      sdaS2_q <= sdaS1_q;
      sdaD_q  <= sdaS2_q;
    end
  end

  wire sclRise   = sclS2_q & ~sclD_q;
  wire sclFall   = ~sclS2_q & sclD_q;
  wire startSeen = ctrl_q.en & sclS2_q & sclD_q & sdaD_q & ~sdaS2_q;
  wire stopSeen  = sclS2_q & sclD_q & ~sdaD_q & sdaS2_q;
  wire countFall = sclFall & busy_q & ~skipFall_q;
  wire fall8     = countFall & (bitCnt_q == 4'h7);
  wire byteEnd   = countFall & (bitCnt_q == `ISM_ACK_BIT);
  wire mActive   = (mState_q != M_IDLE);

  wire wrOwn   = regWr & (regAddr == `ISM_OFS_OWNID);
  wire wrCtrl  = regWr & (regAddr == `ISM_OFS_CTRL);
  wire wrStat  = regWr & (regAddr == `ISM_OFS_STAT);
  wire wrData  = regWr & (regAddr == `ISM_OFS_DATA);
  wire wrEvClr = regWr & (regAddr == `ISM_OFS_EVCLR);
  wire wrEvEn  = regWr & (regAddr == `ISM_OFS_EVEN);
  wire wrExt   = regWr & (regAddr == `ISM_OFS_EXTID);

  // Address decisions, taken on the eighth falling clock of a byte.
  wire own7Hit = ~ctrl_q.ext10 & (shift_q[7:1] == own_q[7:1]);
  wire gcHit   = ctrl_q.gcEn & (shift_q == `ISM_GC_ADDR);
  wire tenHdr  = ctrl_q.ext10 & (shift_q[7:3] == `ISM_TEN_HDR) & (shift_q[2:1] == extId_q[2:1]);
  wire tenLow  = (shift_q == {extId_q[0], own_q[7:1]});
  wire inAddr  = (sState_q == S_ADDR) | (sState_q == S_ADDR2);
  wire sInv    = (sState_q == S_RX) | (sState_q == S_TX) | sAck_q;
  wire matchEv = byteEnd & inAddr & sAck_q & (sNext_q != S_ADDR2);

  wire arbHigh = (mState_q == M_HIGH) & mSda_q & sclS2_q & ~sdaS2_q & (mBit_q < `ISM_ACK_BIT);
  wire arbBusy = (mState_q == M_IDLE) & ctrl_q.mst & ~mstPrev_q & busy_q;
  wire arbEv   = arbHigh | arbBusy;

  always_comb begin
    evtSet.done  = byteEnd & (sInv | mActive);
    evtSet.match = matchEv;
    evtSet.arb   = arbEv;
  end
  wire anyEvt = |evtSet;

  // Bus observer: busy, bit counter and receive shifter.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q     <= 1'b0;
      skipFall_q <= 1'b0;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      rxak_q     <= 1'b1;
    end else begin
      if (startSeen) begin
        busy_q     <= 1'b1;
        skipFall_q <= 1'b1;
        bitCnt_q   <= 4'h0;
      end else if (stopSeen) begin
        busy_q <= 1'b0;
      end else if (sclFall & skipFall_q) begin
        skipFall_q <= 1'b0;
      end else if (countFall) begin
        bitCnt_q <= (bitCnt_q == `ISM_ACK_BIT) ? 4'h0 : bitCnt_q + 4'h1;
      end
      if (sclRise & busy_q & (bitCnt_q < `ISM_ACK_BIT)) begin
        shift_q <= {shift_q[6:0], sdaS2_q};
      end
      if (sclRise & busy_q & (bitCnt_q == `ISM_ACK_BIT)) begin
        rxak_q <= sdaS2_q;
      end
    end
  end

  // Slave engine. It runs whether or not the master lost, so a losing
  // master still answers its own address in the same frame.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sState_q   <= S_IDLE;
      sNext_q    <= S_IGN;
      sAck_q     <= 1'b0;
      dir_q      <= 1'b0;
      tenHeard_q <= 1'b0;
      txShift_q  <= 8'hff;
    end else if (~ctrl_q.en | stopSeen) begin
      sState_q   <= S_IDLE;
      sAck_q     <= 1'b0;
      tenHeard_q <= tenHeard_q & ctrl_q.en & ~stopSeen;
    end else if (startSeen) begin
      sState_q <= S_ADDR;
      sAck_q   <= 1'b0;
    end else if (fall8) begin
      sAck_q  <= 1'b0;
      sNext_q <= S_IGN;
      case (sState_q)
        S_ADDR: begin
          if (own7Hit | gcHit) begin
            sAck_q  <= 1'b1;
            dir_q   <= shift_q[0] & ~gcHit;
            sNext_q <= (shift_q[0] & ~gcHit) ? S_TX : S_RX;
          end else if (tenHdr & ~shift_q[0]) begin
            sAck_q  <= 1'b1;
            sNext_q <= S_ADDR2;
          end else if (tenHdr & tenHeard_q) begin
            sAck_q  <= 1'b1;
            dir_q   <= 1'b1;
            sNext_q <= S_TX;
          end
        end
        S_ADDR2: begin
          if (tenLow) begin
            sAck_q     <= 1'b1;
            dir_q      <= 1'b0;
            tenHeard_q <= 1'b1;
            sNext_q    <= S_RX;
          end
        end
        S_RX: begin
          sAck_q  <= ~ctrl_q.txak;
          sNext_q <= S_RX;
        end
        S_TX: sNext_q <= S_TX;
        default: sNext_q <= S_IGN;
      endcase
    end else if (byteEnd) begin
      sAck_q <= 1'b0;
      if (sState_q == S_TX & rxak_q) begin
        sState_q <= S_IGN;
      end else if (sState_q != S_IDLE) begin
        sState_q <= sNext_q;
      end
      txShift_q <= data_q;
    end else if (countFall & (sState_q == S_TX)) begin
      txShift_q <= {txShift_q[6:0], 1'b1};
    end
  end

  // Slave data only goes out once software has chosen transmit mode.
  wire sTxLow = (sState_q == S_TX) & ctrl_q.tx & (bitCnt_q < `ISM_ACK_BIT) & ~txShift_q[7];

  // Master: start, eight data bits, released acknowledge bit, stop.
  assign mShift7 = mShift_q[7];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mState_q  <= M_IDLE;
      mCnt_q    <= '0;
      mBit_q    <= 4'h0;
      mSda_q    <= 1'b1;
      mScl_q    <= 1'b1;
      mstPrev_q <= 1'b0;
    end else begin
      mstPrev_q <= ctrl_q.mst;
      case (mState_q)
        M_IDLE: begin
          mSda_q <= 1'b1;
          mScl_q <= 1'b1;
          mCnt_q <= '0;
          if (ctrl_q.en & ctrl_q.mst & ~mstPrev_q & ~busy_q) begin
            mSda_q   <= 1'b0;
            mState_q <= M_START;
          end
        end
        M_START: begin
          mCnt_q <= mCnt_q + 1'b1;
          if (mCnt_q == CW'(HALF_CYC)) begin
            mScl_q   <= 1'b0;
            mBit_q   <= 4'h0;
            mCnt_q   <= '0;
            mState_q <= M_LOW;
          end
        end
        M_LOW: begin
          if (~ctrl_q.mst & (mBit_q == 4'h0)) begin
            mSda_q   <= 1'b0;
            mCnt_q   <= '0;
            mState_q <= M_STOP;
          end else if (mHave_q | (mBit_q != 4'h0)) begin
            mCnt_q <= mCnt_q + 1'b1;
            if (mCnt_q == CW'(HALF_CYC / 2)) begin
              mSda_q <= (mBit_q < `ISM_ACK_BIT) ? mShift7 : 1'b1;
            end
            if (mCnt_q == CW'(HALF_CYC)) begin
              mScl_q   <= 1'b1;
              mCnt_q   <= '0;
              mState_q <= M_HIGH;
            end
          end
        end
        M_HIGH: begin
          if (arbHigh) begin
            mSda_q   <= 1'b1;
            mScl_q   <= 1'b1;
            mState_q <= M_IDLE;
          end else if (sclS2_q) begin
            mCnt_q <= mCnt_q + 1'b1;
            if (mCnt_q == CW'(HALF_CYC)) begin
              mScl_q   <= 1'b0;
              mCnt_q   <= '0;
              mBit_q   <= (mBit_q == `ISM_ACK_BIT) ? 4'h0 : mBit_q + 4'h1;
              mState_q <= M_LOW;
            end
          end
        end
        M_STOP: begin
          mCnt_q <= mCnt_q + 1'b1;
          if (mCnt_q == CW'(HALF_CYC)) begin
            mScl_q <= 1'b1;
          end
          if (mCnt_q == CW'(2 * HALF_CYC)) begin
            mSda_q   <= 1'b1;
            mState_q <= M_IDLE;
          end
        end
        default: mState_q <= M_IDLE;
      endcase
    end
  end

  // Transmit byte and its pending mark; the shifter advances per bit.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mShift_q <= 8'hff;
      mHave_q  <= 1'b0;
    end else if (wrData & ctrl_q.mst) begin
      mShift_q <= regWdata;
      mHave_q  <= 1'b1;
    end else if ((mState_q == M_HIGH) & sclS2_q & (mCnt_q == CW'(HALF_CYC))) begin
      mShift_q <= {mShift_q[6:0], 1'b1};
      mHave_q  <= mHave_q & (mBit_q != `ISM_ACK_BIT);
    end
  end

  // Software registers. Only the master request clears in hardware, on lost arbitration or when disabled.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q  <= `ISM_CTRL_RST;
      own_q   <= `ISM_OWNID_RST;
      extId_q <= `ISM_EXTID_RST;
      evtEn_q <= `ISM_EVEN_RST;
    end else begin
      if (wrCtrl) ctrl_q <= regWdata;
      if (arbEv | ~ctrl_q.en) ctrl_q.mst <= 1'b0;
      if (wrOwn) own_q <= regWdata;
      if (wrExt) extId_q <= regWdata;
      if (wrEvEn) evtEn_q <= regWdata[2:0];
    end
  end

  // The address byte lands here after a match, received data otherwise.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_q <= 8'h00;
    end else if (byteEnd & (sInv | mActive) & (sState_q != S_TX)) begin
      data_q <= shift_q;
    end else if (wrData) begin
      data_q <= regWdata;
    end
  end

  // Flags: a hardware set in the same cycle as a clear always wins.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      doneFlag_q  <= 1'b0;
      matchFlag_q <= 1'b0;
      arbFlag_q   <= 1'b0;
      irqFlag_q   <= 1'b0;
      evt_q       <= '0;
    end else begin
      if (evtSet.done) doneFlag_q <= 1'b1;
      else if (sclRise | startSeen) doneFlag_q <= 1'b0;
      if (matchEv) matchFlag_q <= 1'b1;
      else if (startSeen | stopSeen) matchFlag_q <= 1'b0;
      if (arbEv) arbFlag_q <= 1'b1;
      else if (wrStat & regWdata[`ISM_ST_ARB]) arbFlag_q <= 1'b0;
      if (anyEvt) irqFlag_q <= 1'b1;
      else if (wrStat & regWdata[`ISM_ST_IRQ]) irqFlag_q <= 1'b0;
      evt_q <= evtSet | (evt_q & ~({3{wrEvClr}} & regWdata[2:0]));
    end
  end

  wire [7:0] statWord = {doneFlag_q, matchFlag_q, busy_q, arbFlag_q, 1'b0, dir_q, irqFlag_q, rxak_q};
  wire [7:0] rdSel = (regAddr == `ISM_OFS_OWNID) ? {own_q[7:1], 1'b0} :
                     (regAddr == `ISM_OFS_CTRL)  ? ctrl_q :
                     (regAddr == `ISM_OFS_STAT)  ? statWord :
                     (regAddr == `ISM_OFS_DATA)  ? data_q :
                     (regAddr == `ISM_OFS_EVT)   ? {5'h00, evt_q} :
                     (regAddr == `ISM_OFS_EVEN)  ? {5'h00, evtEn_q} :
                     (regAddr == `ISM_OFS_EXTID) ? {5'h00, extId_q[2:0]} : 8'h00;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= regRd ? rdSel : 8'h00;
      sclOe_q <= ctrl_q.en & ~mScl_q;
      sdaOe_q <= ctrl_q.en & (~mSda_q | sAck_q | sTxLow);
      // This single line is the only request leaving the block; it cannot reset the processor.
      irq_q   <= ctrl_q.irqEn & irqFlag_q & |(evt_q & evtEn_q);
    end
  end

  assign regRdata = rdata_q;
  assign sclOut   = 1'b0;
  assign sdaOut   = 1'b0;
  assign sclOe    = sclOe_q;
  assign sdaOe    = sdaOe_q;
  assign irq      = irq_q;

  property p_offQuiet;
    @(posedge clk) disable iff (reset) !ctrl_q.en |=> !sdaOe && !sclOe;
  endproperty
  a_offQuiet: assert property (p_offQuiet) else $error("disabled core drives a line");

  property p_irqMask;
    @(posedge clk) disable iff (reset) !ctrl_q.irqEn ##1 !ctrl_q.irqEn |-> !irq;
  endproperty
  a_irqMask: assert property (p_irqMask) else $error("interrupt not masked by enable");

  property p_flagHolds;
    @(posedge clk) disable iff (reset) irqFlag_q && !(wrStat && regWdata[`ISM_ST_IRQ]) |=> irqFlag_q;
  endproperty
  a_flagHolds: assert property (p_flagHolds) else $error("interrupt flag dropped without write");

  property p_flagClr;
    @(posedge clk) disable iff (reset) wrStat && regWdata[`ISM_ST_IRQ] && !anyEvt |=> !irqFlag_q;
  endproperty
  a_flagClr: assert property (p_flagClr) else $error("write of one did not clear flag");

  property p_doneSets;
    @(posedge clk) disable iff (reset) byteEnd && sInv |=> doneFlag_q && irqFlag_q;
  endproperty
  a_doneSets: assert property (p_doneSets) else $error("byte end did not flag");

  property p_matchData;
    @(posedge clk) disable iff (reset) matchEv |=> matchFlag_q && irqFlag_q && data_q == $past(shift_q);
  endproperty
  a_matchData: assert property (p_matchData) else $error("match flag or address byte missing");

  property p_gcIgnored;
    @(posedge clk) disable iff (reset)
      sState_q == S_ADDR && fall8 && shift_q == 8'h00 && !ctrl_q.gcEn && own_q[7:1] != 7'h00 |=> !sAck_q;
  endproperty
  a_gcIgnored: assert property (p_gcIgnored) else $error("general call answered while disabled");

  property p_gcTaken;
    @(posedge clk) disable iff (reset)
      sState_q == S_ADDR && fall8 && shift_q == 8'h00 && ctrl_q.gcEn && ctrl_q.en |=> sAck_q && sNext_q == S_RX;
  endproperty
  a_gcTaken: assert property (p_gcTaken) else $error("general call not taken as receiver");

  property p_ownHit;
    @(posedge clk) disable iff (reset)
      sState_q == S_ADDR && fall8 && !ctrl_q.ext10 && shift_q[7:1] == own_q[7:1] && ctrl_q.en |=> sAck_q;
  endproperty
  a_ownHit: assert property (p_ownHit) else $error("own address not acknowledged");

  property p_arbRelease;
    @(posedge clk) disable iff (reset) arbHigh |=> mState_q == M_IDLE && arbFlag_q && !ctrl_q.mst ##1 !sclOe;
  endproperty
  a_arbRelease: assert property (p_arbRelease) else $error("bus not released after lost arbitration");

  c_match: cover property (@(posedge clk) disable iff (reset) matchEv);
  c_arb:   cover property (@(posedge clk) disable iff (reset) arbHigh);
  c_irq:   cover property (@(posedge clk) disable iff (reset) $rose(irq));
  c_mstByte: cover property (@(posedge clk) disable iff (reset) byteEnd && mActive);
  c_slvTx: cover property (@(posedge clk) disable iff (reset) sTxLow);
endmodule

// [src/ism_map.svh]
// Register offsets, field positions, reset values and timing for the
// two-wire slave-match block. Included by the core and the testbench.
`ifndef ISM_MAP_SVH
`define ISM_MAP_SVH
`define ISM_OFS_OWNID  3'h0
`define ISM_OFS_CTRL   3'h1
`define ISM_OFS_STAT   3'h2
`define ISM_OFS_DATA   3'h3
`define ISM_OFS_EVT    3'h4
`define ISM_OFS_EVCLR  3'h5
`define ISM_OFS_EVEN   3'h6
`define ISM_OFS_EXTID  3'h7
`define ISM_ST_DONE    7
`define ISM_ST_MATCH   6
`define ISM_ST_BUSY    5
`define ISM_ST_ARB     4
`define ISM_ST_DIR     2
`define ISM_ST_IRQ     1
`define ISM_ST_RXAK    0
`define ISM_CTRL_RST   8'h00
`define ISM_OWNID_RST  8'h00
`define ISM_EXTID_RST  8'h00
`define ISM_EVEN_RST   3'h7
`define ISM_GC_ADDR    8'h00
`define ISM_TEN_HDR    5'h1e
`define ISM_ACK_BIT    4'h8
`define ISM_HALF_NS    1250
`define ISM_CLK_MHZ    250
`define ISM_HALF_CYC   ((`ISM_HALF_NS * `ISM_CLK_MHZ + 999) / 1000)
`endif

// [src/ism_pkg.sv]
// Types shared by the slave-match block.
// Assumes ism_map.svh is on the include path.
package ism_pkg;
  typedef struct packed {
    logic en;
    logic irqEn;
    logic mst;
    logic tx;
    logic txak;
    logic gcEn;
    logic ext10;
    logic spare;
  } ism_ctrl_type;
  typedef struct packed {
    logic arb;
    logic match;
    logic done;
  } ism_evt_type;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_RX, S_TX, S_IGN} ism_sst_type;
  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP} ism_mst_type;
endpackage

// [testbench/ism_bus_master_model.sv]
// Behavioural two-wire partner: a master that calls the block, and a
// listener that answers the block's own master.
// Assumes open-drain wires with pull-ups resolved by the bench.
module ism_bus_master_model (
  input  wire logic sclWire,
  input  wire logic sdaWire,
  output logic      mSclOe,
  output logic      mSdaOe
);
  timeunit 1ns;
  timeprecision 100ps;
  // A quarter of the 80 ns bus clock period.
  localparam time Q = 20ns;
  initial begin
    mSclOe = 1'b0;
    mSdaOe = 1'b0;
  end
  // Works from idle and as a repeated start, since both lines are let go first.
  task automatic start_cond();
    mSdaOe = 1'b0;
    #Q mSclOe = 1'b0;
    #Q mSdaOe = 1'b1;
    #Q mSclOe = 1'b1;
    #Q;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      mSdaOe = ~b[i];
      #Q mSclOe = 1'b0;
      #(2 * Q) mSclOe = 1'b1;
      #Q;
    end
    // Data is let go so that only the slave can pull it; a silent slave reads high.
    mSdaOe = 1'b0;
    #Q mSclOe = 1'b0;
    #Q ack = ~sdaWire;
    #Q mSclOe = 1'b1;
    #Q;
  endtask
  task automatic stop_cond();
    mSdaOe = 1'b1;
    #Q mSclOe = 1'b0;
    #Q mSdaOe = 1'b0;
    #Q;
  endtask
  // Clocks one byte out of the block as slave; nak high leaves the ninth bit released.
  task automatic recv_byte(input logic nak, output logic [7:0] b);
    mSdaOe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #Q mSclOe = 1'b0;
      #Q b[i] = sdaWire;
      #Q mSclOe = 1'b1;
      #Q;
    end
    mSdaOe = ~nak;
    #Q mSclOe = 1'b0;
    #(2 * Q) mSclOe = 1'b1;
    #Q mSdaOe = 1'b0;
  endtask
  // Follows a byte that the block sends as master and answers its ninth clock.
  task automatic watch_byte(input logic nak, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sclWire) b[i] = sdaWire;
    end
    @(negedge sclWire) mSdaOe = ~nak;
    @(negedge sclWire) mSdaOe = 1'b0;
  endtask
  // Holds data low, or lets it go, to contend with the block's master.
  task automatic sda_hold(input logic low);
    mSdaOe = low;
  endtask
endmodule

// [testbench/tb_i2c_slave_match_and_irq.sv]
// Self-checking bench for the slave-match block.
// Assumes the core, its register map header and the bus master model.
`include "ism_map.svh"
module tb_i2c_slave_match_and_irq
  import ism_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regRdata;
  logic       sclOut, sclOe, sdaOut, sdaOe, irq, mSclOe, mSdaOe, ack;
  wire        sclWire = (sclOe ? sclOut : 1'b1) & ~mSclOe;
  wire        sdaWire = (sdaOe ? sdaOut : 1'b1) & ~mSdaOe;
  int         numErrors = 0;
  int         totalChecks = 0;
  int         cycles = 0;
  int         seed = 32'h3ee133e4;
  logic [7:0] own, dat, got;
  logic [2:0] ext;

  ism_core #(.HALF_CYC(8)) dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclWire), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
  ism_bus_master_model bm (.sclWire(sclWire), .sdaWire(sdaWire), .mSclOe(mSclOe), .mSdaOe(mSdaOe));

  always #2 clk = ~clk;

  function automatic logic [7:0] ctrl_val(input logic ie, input logic gc, input logic ten);
    ism_ctrl_type c;
    c = '0;
    c.en = 1'b1;
    c.irqEn = ie;
    c.gcEn = gc;
    c.ext10 = ten;
    return c;
  endfunction

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      giveVerdict();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(what, e & m, regRdata & m);
  endtask

  task automatic call(input string what, input logic [7:0] b, input logic e);
    bm.start_cond();
    bm.send_byte(b, ack);
    check(what, {7'h0, e}, {7'h0, ack});
    repeat (4) @(posedge clk);
  endtask

  // Clears the arbitration and interrupt flags and every event so the next test starts quiet.
  task automatic clear_all(input string name);
    wr(`ISM_OFS_STAT, 8'h12);
    wr(`ISM_OFS_EVCLR, 8'h07);
    $display("test %s finished", name);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdchk("ctrl enable", `ISM_OFS_CTRL, 8'h80, 8'h00);
    rdchk("event enable", `ISM_OFS_EVEN, 8'h07, 8'h07);
    rdchk("event clear", `ISM_OFS_EVCLR, 8'hff, 8'h00);
    check("irq", 8'h00, {7'h0, irq});
    own = 8'(((($random(seed) & 63) + 8) * 2));
    wr(`ISM_OFS_OWNID, own | 8'h01);
    rdchk("own id", `ISM_OFS_OWNID, 8'hff, own);
    call("ack while off", own, 1'b0);
    bm.stop_cond();
    clear_all("reset");
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0));
    call("own ack", own, 1'b1);
    rdchk("status", `ISM_OFS_STAT, 8'hd2, 8'hc2);
    rdchk("address byte", `ISM_OFS_DATA, 8'hff, own);
    check("irq", 8'h01, {7'h0, irq});
    bm.stop_cond();
    wr(`ISM_OFS_STAT, 8'h00);
    repeat (3) @(posedge clk);
    check("irq kept", 8'h01, {7'h0, irq});
    wr(`ISM_OFS_STAT, 8'h02);
    repeat (3) @(posedge clk);
    check("irq cleared", 8'h00, {7'h0, irq});
    clear_all("own address");
    for (int i = 0; i < 3; i++) begin
      dat = own ^ 8'(((($random(seed) & 62) + 2) * 2));
      call("other ack", dat, 1'b0);
      rdchk("no match", `ISM_OFS_STAT, 8'h40, 8'h00);
      bm.stop_cond();
    end
    clear_all("mismatch");
    call("gc off ack", `ISM_GC_ADDR, 1'b0);
    bm.stop_cond();
    wr(`ISM_OFS_CTRL, ctrl_val(1'b0, 1'b1, 1'b0));
    call("gc ack", `ISM_GC_ADDR, 1'b1);
    rdchk("gc byte", `ISM_OFS_DATA, 8'hff, 8'h00);
    rdchk("gc status", `ISM_OFS_STAT, 8'h42, 8'h42);
    check("masked irq", 8'h00, {7'h0, irq});
    dat = 8'($random(seed));
    bm.send_byte(dat, ack);
    check("gc data ack", 8'h01, {7'h0, ack});
    bm.stop_cond();
    clear_all("general call");
    ext = 3'($random(seed));
    wr(`ISM_OFS_EXTID, {5'h0, ext});
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b1));
    call("header ack", {`ISM_TEN_HDR, ext[2:1], 1'b0}, 1'b1);
    bm.send_byte({ext[0], own[7:1]}, ack);
    check("low ack", 8'h01, {7'h0, ack});
    repeat (4) @(posedge clk);
    rdchk("ten match", `ISM_OFS_STAT, 8'h40, 8'h40);
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b1) | 8'h08);
    bm.send_byte(dat, ack);
    check("refused data ack", 8'h00, {7'h0, ack});
    bm.stop_cond();
    clear_all("ten bit");
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0));
    bm.start_cond();
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0) | 8'h20);
    repeat (6) @(posedge clk);
    rdchk("arb status", `ISM_OFS_STAT, 8'h12, 8'h12);
    rdchk("master off", `ISM_OFS_CTRL, 8'h20, 8'h00);
    check("lines", 8'h00, {6'h0, sdaOe, sclOe});
    check("arb irq", 8'h01, {7'h0, irq});
    bm.send_byte(own, ack);
    check("watch ack", 8'h01, {7'h0, ack});
    bm.stop_cond();
    clear_all("arbitration");
    dat = 8'($random(seed));
    wr(`ISM_OFS_DATA, dat);
    call("read ack", own | 8'h01, 1'b1);
    rdchk("direction", `ISM_OFS_STAT, 8'h04, 8'h04);
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0) | 8'h10);
    bm.recv_byte(1'b1, got);
    check("slave byte", dat, got);
    bm.stop_cond();
    clear_all("slave transmit");
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0) | 8'h20);
    wr(`ISM_OFS_DATA, own ^ 8'h80);
    bm.watch_byte(1'b0, got);
    check("master byte", own ^ 8'h80, got);
    repeat (4) @(posedge clk);
    rdchk("master done", `ISM_OFS_STAT, 8'h83, 8'h82);
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0));
    repeat (32) @(posedge clk);
    rdchk("stop sent", `ISM_OFS_STAT, 8'h20, 8'h00);
    check("stop lines", 8'h00, {6'h0, sdaOe, sclOe});
    clear_all("master transmit");
    wr(`ISM_OFS_CTRL, ctrl_val(1'b1, 1'b0, 1'b0) | 8'h20);
    @(negedge sclWire);
    bm.sda_hold(1'b1);
    wr(`ISM_OFS_DATA, 8'hff);
    repeat (20) @(posedge clk);
    rdchk("data arb", `ISM_OFS_STAT, 8'h12, 8'h12);
    rdchk("data arb master", `ISM_OFS_CTRL, 8'h20, 8'h00);
    check("data arb lines", 8'h00, {6'h0, sdaOe, sclOe});
    bm.sda_hold(1'b0);
    repeat (8) @(posedge clk);
    clear_all("data arbitration");
    giveVerdict();
  end
endmodule
